/* File: hw/tmr_core.sv */
// Single-channel 8-bit timer/counter with one compare unit and waveform output.
module tmr_core
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control bits
    input wire tmr_pkg::tmr_ctrl_t ctrl,
    // Processor accesses, one-cycle strobes with data
    input wire tmr_pkg::tmr_cpu_t cpu,
    // Crystal oscillator pin
    input wire logic crystalOscPinA,
    // Readable state
    output tmr_pkg::tmr_stat_t stat,
    // Interrupt requests
    output logic overflowIrq,
    output logic compareIrq,
    // Waveform pin
    output logic compareOutput,
    output logic compareOutputOverride
);
    import tmr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////

    tmr_core_state_t s_q;
    tmr_core_state_t s_d;
    logic tick;
    logic pwm;
    logic [7:0] topValue;
    logic atTop;
    logic atMax;
    logic atBottom;
    logic matchNow;
    logic matchEvent;
    logic bottomEvent;
    logic overflowEvent;
    logic updatePoint;
    logic ocNext;

    ////////////////////////////////////////////////////////////////////////////////

    tmr_tick_gen u_tick
    (
        .clk(clk),
        .rst(rst),
        .clockSourceSelect(ctrl.clockSourceSelect),
        .asyncClockSelect(ctrl.asyncClockSelect),
        .crystalOscPinA(crystalOscPinA),
        .tick(tick)
    );

    tmr_wave_gen u_wave
    (
        .waveformModeSelect(ctrl.waveformModeSelect),
        .compareOutputMode(ctrl.compareOutputMode),
        .matchEvent(matchEvent),
        .bottomEvent(bottomEvent),
        .countingUp(~s_q.countDown),
        .forceCompare(cpu.forceCompare),
        .ocState(s_q.ocState),
        .ocNext(ocNext)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Event decode from the registered state.

    always_comb
    begin
        pwm = ctrl.waveformModeSelect[TMR_WGM_PWM_BIT];
        // Clear-on-match tops out at the compare value, every other mode at max.
        topValue = (ctrl.waveformModeSelect == TMR_WGM_CTC) ? s_q.compareReg : TMR_MAX;
        atTop = (s_q.counter == topValue);
        atMax = (s_q.counter == TMR_MAX);
        atBottom = (s_q.counter == TMR_BOTTOM);
        // The comparator runs every cycle; its result acts only on a tick.
        matchNow = (s_q.counter == s_q.compareReg);
        // A pending or simultaneous counter write swallows the match.
        matchEvent = tick && matchNow && !s_q.blockMatch && !cpu.counterWr;
        bottomEvent = 1'b0;
        updatePoint = 1'b0;
        overflowEvent = 1'b0;
        case (ctrl.waveformModeSelect)
            TMR_WGM_NORMAL, TMR_WGM_CTC:
            begin
                overflowEvent = tick && atMax;
            end
            TMR_WGM_FAST:
            begin
                overflowEvent = tick && atMax;
                bottomEvent = tick && atMax;
                updatePoint = tick && atMax;
            end
            TMR_WGM_PHASE:
            begin
                // Dual slope: overflow at the turn at bottom, reload at the turn at top.
                overflowEvent = tick && atBottom && s_q.countDown;
                updatePoint = tick && atMax && !s_q.countDown;
            end
            default:
            begin
                overflowEvent = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb
    begin
        s_d = s_q;

        // Counting sequence; no tick means the counter simply holds.
        if (tick)
        begin
            s_d.blockMatch = 1'b0;
            case (ctrl.waveformModeSelect)
                TMR_WGM_NORMAL, TMR_WGM_FAST:
                begin
                    s_d.counter = s_q.counter + 8'h01;
                    s_d.countDown = 1'b0;
                end
                TMR_WGM_CTC:
                begin
                    s_d.countDown = 1'b0;
                    if (atTop)
                        s_d.counter = TMR_BOTTOM;
                    else
                        s_d.counter = s_q.counter + 8'h01;
                end
                TMR_WGM_PHASE:
                begin
                    if (!s_q.countDown)
                    begin
                        if (atMax)
                        begin
                            s_d.countDown = 1'b1;
                            s_d.counter = s_q.counter - 8'h01;
                        end
                        else
                        begin
                            s_d.counter = s_q.counter + 8'h01;
                        end
                    end
                    else
                    begin
                        if (atBottom)
                        begin
                            s_d.countDown = 1'b0;
                            s_d.counter = s_q.counter + 8'h01;
                        end
                        else
                        begin
                            s_d.counter = s_q.counter - 8'h01;
                        end
                    end
                end
                default:
                begin
                    s_d.counter = s_q.counter;
                end
            endcase
        end

        // A processor write lands last so it overrides any count or clear.
        if (cpu.counterWr)
        begin
            s_d.counter = cpu.counterWrData;
            s_d.blockMatch = 1'b1;
        end

        // Compare value: buffered in PWM modes, direct otherwise.
        if (pwm && updatePoint)
        begin
            s_d.compareReg = s_q.compareBuf;
        end
        if (cpu.compareWr)
        begin
            s_d.compareBuf = cpu.compareWrData;
            if (!pwm)
            begin
                s_d.compareReg = cpu.compareWrData;
            end
        end

        // Flags: clear first, so an event in the same cycle still sets the flag.
        if (cpu.overflowFlagClr || cpu.overflowIrqAck)
        begin
            s_d.overflowFlag = 1'b0;
        end
        if (overflowEvent)
        begin
            s_d.overflowFlag = 1'b1;
        end
        if (cpu.compareFlagClr || cpu.compareIrqAck)
        begin
            s_d.compareFlag = 1'b0;
        end
        if (matchEvent)
        begin
            s_d.compareFlag = 1'b1;
        end

        // Output state; the force strobe never touches flag or counter.
        s_d.ocState = ocNext;
    end

    ////////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_q.counter <= TMR_CNT_RESET;
            s_q.compareReg <= TMR_CMP_RESET;
            s_q.compareBuf <= TMR_CMP_RESET;
            s_q.countDown <= 1'b0;
            s_q.blockMatch <= 1'b0;
            s_q.overflowFlag <= 1'b0;
            s_q.compareFlag <= 1'b0;
            s_q.ocState <= TMR_OC_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    always_comb
    begin
        stat.counterValue = s_q.counter;
        // Reads follow writes: buffer while buffering, register otherwise.
        stat.compareValue = pwm ? s_q.compareBuf : s_q.compareReg;
        stat.overflowFlag = s_q.overflowFlag;
        stat.compareMatchFlag = s_q.compareFlag;
    end

    assign overflowIrq = s_q.overflowFlag & ctrl.overflowIrqEnable;
    assign compareIrq = s_q.compareFlag & ctrl.compareIrqEnable;
    assign compareOutput = s_q.ocState;
    // Any nonzero output mode hands the pin to the waveform generator.
    assign compareOutputOverride = (ctrl.compareOutputMode != TMR_COM_NONE);

endmodule

/* File: hw/tmr_pkg.sv */
// Shared constants and carrier types for the 8-bit single-compare timer.
package tmr_pkg;

    localparam int TMR_CNT_W = 8;
    localparam int TMR_PRE_W = 10;

    localparam logic [7:0] TMR_BOTTOM = 8'h00;
    localparam logic [7:0] TMR_MAX = 8'hff;
    localparam logic [7:0] TMR_CNT_RESET = 8'h00;
    localparam logic [7:0] TMR_CMP_RESET = 8'h00;
    localparam logic TMR_OC_RESET = 1'b0;

    // Waveform mode encodings; bit 0 set marks the PWM modes.
    localparam logic [1:0] TMR_WGM_NORMAL = 2'h0;
    localparam logic [1:0] TMR_WGM_PHASE = 2'h1;
    localparam logic [1:0] TMR_WGM_CTC = 2'h2;
    localparam logic [1:0] TMR_WGM_FAST = 2'h3;
    localparam int TMR_WGM_PWM_BIT = 0;

    // Compare output mode encodings.
    localparam logic [1:0] TMR_COM_NONE = 2'h0;
    localparam logic [1:0] TMR_COM_TOGGLE = 2'h1;
    localparam logic [1:0] TMR_COM_CLEAR = 2'h2;
    localparam logic [1:0] TMR_COM_SET = 2'h3;

    // Clock select: 0 stops, 1..7 divide the source by 1,8,32,64,128,256,1024.
    localparam logic [2:0] TMR_CS_STOP = 3'h0;
    localparam logic [9:0] TMR_PRE_MASK_1 = 10'h000;
    localparam logic [9:0] TMR_PRE_MASK_8 = 10'h007;
    localparam logic [9:0] TMR_PRE_MASK_32 = 10'h01f;
    localparam logic [9:0] TMR_PRE_MASK_64 = 10'h03f;
    localparam logic [9:0] TMR_PRE_MASK_128 = 10'h07f;
    localparam logic [9:0] TMR_PRE_MASK_256 = 10'h0ff;
    localparam logic [9:0] TMR_PRE_MASK_1024 = 10'h3ff;
    localparam logic [9:0] TMR_PRE_RESET = 10'h000;

    typedef struct packed {
        logic [2:0] clockSourceSelect;
        logic asyncClockSelect;
        logic [1:0] waveformModeSelect;
        logic [1:0] compareOutputMode;
        logic overflowIrqEnable;
        logic compareIrqEnable;
    } tmr_ctrl_t;

    typedef struct packed {
        logic counterWr;
        logic [7:0] counterWrData;
        logic compareWr;
        logic [7:0] compareWrData;
        logic forceCompare;
        logic overflowFlagClr;
        logic compareFlagClr;
        logic overflowIrqAck;
        logic compareIrqAck;
    } tmr_cpu_t;

    typedef struct packed {
        logic [7:0] counterValue;
        logic [7:0] compareValue;
        logic overflowFlag;
        logic compareMatchFlag;
    } tmr_stat_t;

    typedef struct packed {
        logic pinMeta;
        logic pinSync;
        logic pinPrev;
        logic [9:0] prescale;
        logic tick;
    } tmr_tick_state_t;

    typedef struct packed {
        logic [7:0] counter;
        logic [7:0] compareReg;
        logic [7:0] compareBuf;
        logic countDown;
        logic blockMatch;
        logic overflowFlag;
        logic compareFlag;
        logic ocState;
    } tmr_core_state_t;

endpackage

/* File: hw/tmr_tick_gen.sv */
// Timer tick source: io clock or synchronised crystal pin, through the prescaler.
module tmr_tick_gen
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Selection
    input wire logic [2:0] clockSourceSelect,
    input wire logic asyncClockSelect,
    // Crystal oscillator pin
    input wire logic crystalOscPinA,
    // Tick strobe
    output logic tick
);
    import tmr_pkg::*;

    tmr_tick_state_t s_q;
    tmr_tick_state_t s_d;
    logic srcPulse;
    logic [9:0] mask;

    always_comb
    begin
        s_d = s_q;
        s_d.pinMeta = crystalOscPinA;
        s_d.pinSync = s_q.pinMeta;
        s_d.pinPrev = s_q.pinSync;
        // The crystal is far slower than clk, so one rising edge is one source pulse.
        srcPulse = asyncClockSelect ? (s_q.pinSync & ~s_q.pinPrev) : 1'b1;
        case (clockSourceSelect)
            3'h1: mask = TMR_PRE_MASK_1;
            3'h2: mask = TMR_PRE_MASK_8;
            3'h3: mask = TMR_PRE_MASK_32;
            3'h4: mask = TMR_PRE_MASK_64;
            3'h5: mask = TMR_PRE_MASK_128;
            3'h6: mask = TMR_PRE_MASK_256;
            3'h7: mask = TMR_PRE_MASK_1024;
            default: mask = TMR_PRE_MASK_1;
        endcase
        s_d.tick = 1'b0;
        if (clockSourceSelect == TMR_CS_STOP)
        begin
            s_d.prescale = TMR_PRE_RESET;
        end
        else if (srcPulse)
        begin
            s_d.tick = ((s_q.prescale & mask) == mask);
            s_d.prescale = s_q.prescale + 10'h001;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;

endmodule

/* File: hw/tmr_wave_gen.sv */
// Next compare output state from match, bottom and force events.
module tmr_wave_gen
(
    // Configuration
    input wire logic [1:0] waveformModeSelect,
    input wire logic [1:0] compareOutputMode,
    // Events
    input wire logic matchEvent,
    input wire logic bottomEvent,
    input wire logic countingUp,
    input wire logic forceCompare,
    // Output state
    input wire logic ocState,
    output logic ocNext
);
    import tmr_pkg::*;

    logic pwm;

    always_comb
    begin
        pwm = waveformModeSelect[TMR_WGM_PWM_BIT];
        ocNext = ocState;
        case (waveformModeSelect)
            TMR_WGM_NORMAL, TMR_WGM_CTC:
            begin
                // Force acts only outside PWM and mimics a match.
                if (matchEvent || (forceCompare && !pwm))
                begin
                    case (compareOutputMode)
                        TMR_COM_TOGGLE: ocNext = ~ocState;
                        TMR_COM_CLEAR: ocNext = 1'b0;
                        TMR_COM_SET: ocNext = 1'b1;
                        default: ocNext = ocState;
                    endcase
                end
            end
            TMR_WGM_FAST:
            begin
                // Bottom wins over a same-tick match, so compare at max gives a steady level.
                if (bottomEvent)
                begin
                    if (compareOutputMode == TMR_COM_CLEAR)
                        ocNext = 1'b1;
                    else if (compareOutputMode == TMR_COM_SET)
                        ocNext = 1'b0;
                end
                else if (matchEvent)
                begin
                    if (compareOutputMode == TMR_COM_CLEAR)
                        ocNext = 1'b0;
                    else if (compareOutputMode == TMR_COM_SET)
                        ocNext = 1'b1;
                end
            end
            TMR_WGM_PHASE:
            begin
                if (matchEvent)
                begin
                    if (compareOutputMode == TMR_COM_CLEAR)
                        ocNext = ~countingUp;
                    else if (compareOutputMode == TMR_COM_SET)
                        ocNext = countingUp;
                end
            end
            default: ocNext = ocState;
        endcase
    end

endmodule

/* File: test/tmr_core_sva.sv */
// Port-level property checker for the timer core.
module tmr_core_sva
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Inputs
    input wire tmr_pkg::tmr_ctrl_t ctrl,
    input wire tmr_pkg::tmr_cpu_t cpu,
    input wire logic crystalOscPinA,
    // Outputs
    input wire tmr_pkg::tmr_stat_t stat,
    input wire logic overflowIrq,
    input wire logic compareIrq,
    input wire logic compareOutput,
    input wire logic compareOutputOverride
);
    timeunit 1ns;
    timeprecision 1ns;
    import tmr_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    // The tick strobe is a flop, so three stopped cycles guarantee no tick.
    logic [1:0] stopHist_q;
    logic idle;
    always_ff @(posedge clk)
        stopHist_q <= {stopHist_q[0], ctrl.clockSourceSelect == TMR_CS_STOP};
    assign idle = stopHist_q == 2'b11 && ctrl.clockSourceSelect == TMR_CS_STOP;
    ////////////////////////////////////////////////////////////////////////////////
    a_stop_holds: assert property (idle && !cpu.counterWr |=> $stable(stat.counterValue))
        else $error("counter moved while stopped");
    a_write_loads: assert property (cpu.counterWr |=> stat.counterValue == $past(cpu.counterWrData))
        else $error("counter write lost");
    a_cmp_access: assert property (cpu.compareWr ##1 $stable(ctrl.waveformModeSelect)
        |-> stat.compareValue == $past(cpu.compareWrData)) else $error("compare write lost");
    a_irq_gate: assert property (overflowIrq == (stat.overflowFlag && ctrl.overflowIrqEnable)
        && compareIrq == (stat.compareMatchFlag && ctrl.compareIrqEnable)) else $error("irq gate");
    a_flag_clear: assert property (idle && (cpu.compareFlagClr || cpu.compareIrqAck)
        |=> !stat.compareMatchFlag) else $error("match flag not cleared");
    a_override_now: assert property (compareOutputOverride == (ctrl.compareOutputMode != 0))
        else $error("override wrong");
    a_com_none: assert property (ctrl.compareOutputMode == TMR_COM_NONE |=> $stable(compareOutput))
        else $error("output changed with no action");
    a_force_toggle: assert property (idle && cpu.forceCompare && !ctrl.waveformModeSelect[0]
        && ctrl.compareOutputMode == TMR_COM_TOGGLE |=> compareOutput != $past(compareOutput))
        else $error("force did not toggle");
    a_wrap_flag: assert property (!$past(rst) && $past(stat.counterValue) == TMR_MAX
        && stat.counterValue == TMR_BOTTOM && !$past(cpu.counterWr)
        && $past(ctrl.waveformModeSelect) == TMR_WGM_NORMAL |-> stat.overflowFlag)
        else $error("overflow flag missing");
    a_match_flag: assert property ($past(stat.counterValue) == $past(stat.compareValue)
        && stat.counterValue == 8'($past(stat.counterValue) + 8'h01)
        && $past(stat.counterValue) == 8'($past(stat.counterValue, 2) + 8'h01)
        && !$past(cpu.counterWr) && !$past(cpu.counterWr, 2)
        && $past(ctrl.waveformModeSelect) == TMR_WGM_NORMAL |-> stat.compareMatchFlag)
        else $error("match flag missing");
    c_overflow: cover property ($rose(stat.overflowFlag));
    c_match: cover property ($rose(stat.compareMatchFlag));
    c_force: cover property (idle && cpu.forceCompare);
endmodule
bind tmr_core tmr_core_sva u_sva (.clk(clk), .rst(rst), .ctrl(ctrl), .cpu(cpu),
    .crystalOscPinA(crystalOscPinA), .stat(stat), .overflowIrq(overflowIrq),
    .compareIrq(compareIrq), .compareOutput(compareOutput),
    .compareOutputOverride(compareOutputOverride));

/* File: test/testbench.sv */
// Self-checking bench for the timer core.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import tmr_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    tmr_ctrl_t ctrl = '0;
    tmr_cpu_t cpu = '0;
    logic pinA = 1'b0;
    tmr_stat_t stat;
    logic ovIrq, cmpIrq, oc, ocOe, ex;
    int n_mismatch = 0;
    int num_checks = 0;
    tmr_ctrl_t cf = '0;
    tmr_cpu_t c;
    logic [7:0] v, w, prev;
    logic [1:0] modes [3] = '{TMR_WGM_NORMAL, TMR_WGM_CTC, TMR_WGM_FAST};
    logic [1:0] coms [5] = '{TMR_COM_SET, TMR_COM_TOGGLE, TMR_COM_CLEAR, TMR_COM_TOGGLE,
        TMR_COM_NONE};

    always #50 clk = ~clk;

    tmr_core DUT (.clk(clk), .rst(rst), .ctrl(ctrl), .cpu(cpu), .crystalOscPinA(pinA),
        .stat(stat), .overflowIrq(ovIrq), .compareIrq(cmpIrq), .compareOutput(oc),
        .compareOutputOverride(ocOe));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] nxt(logic [1:0] m, logic [7:0] cv, logic [7:0] cp);
        return (m == TMR_WGM_CTC && cv == cp) ? TMR_BOTTOM : cv + 8'h01;
    endfunction
    function automatic logic wave(logic [1:0] com, logic cur);
        return com == TMR_COM_TOGGLE ? ~cur : com == TMR_COM_CLEAR ? 1'b0
            : com == TMR_COM_SET ? 1'b1 : cur;
    endfunction
    task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Sampling one step after the edge keeps reads clear of the design's own updates.
    task automatic step(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic setc();
        @(posedge clk);
        ctrl <= cf;
        step(1);
    endtask
    task automatic put(tmr_cpu_t p);
        @(posedge clk);
        cpu <= p;
        @(posedge clk);
        cpu <= '0;
        #1;
    endtask
    task automatic wr(logic [7:0] d, bit toCmp);
        c = '0;
        c.counterWr = !toCmp;
        c.counterWrData = d;
        c.compareWr = toCmp;
        c.compareWrData = d;
        put(c);
    endtask
    task automatic clr();
        c = '0;
        c.overflowFlagClr = 1'b1;
        c.compareFlagClr = 1'b1;
        put(c);
    endtask
    task automatic force_cmp();
        c = '0;
        c.forceCompare = 1'b1;
        put(c);
    endtask
    task automatic runfor(int n);
        cf.clockSourceSelect = 3'h1;
        setc();
        step(n);
        cf.clockSourceSelect = TMR_CS_STOP;
        setc();
        step(2);
    endtask
    task automatic reach(logic [7:0] t);
        for (int i = 0; i < 300 && stat.counterValue !== t; i++)
            step(1);
        chk("count reached", stat.counterValue, t);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #2000000;
        n_mismatch++;
        report_and_stop();
    end

    initial
    begin
        void'($urandom(32'h9823d9f1));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        step(1);
        chk("reset counter", stat.counterValue, TMR_CNT_RESET);
        chk("reset compare", stat.compareValue, TMR_CMP_RESET);
        chk("reset flags", {stat.overflowFlag, stat.compareMatchFlag}, 2'b00);
        chk("reset output", oc, TMR_OC_RESET);
        v = 8'($urandom);
        wr(v, 0);
        chk("counter write", stat.counterValue, v);
        step(5);
        chk("stopped counter", stat.counterValue, v);
        cf.compareIrqEnable = 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            cf.waveformModeSelect = modes[i];
            setc();
            w = 8'h02 + 8'($urandom_range(7));
            wr(w, 1);
            wr(8'hf0 + 8'($urandom_range(7)), 0);
            clr();
            cf.clockSourceSelect = 3'h1;
            setc();
            step(2);
            repeat (40)
            begin
                prev = stat.counterValue;
                step(1);
                chk("count", stat.counterValue, nxt(modes[i], prev, w));
            end
            cf.clockSourceSelect = TMR_CS_STOP;
            setc();
            step(2);
            chk("overflow flag", stat.overflowFlag, 1'b1);
            chk("match flag", stat.compareMatchFlag, 1'b1);
            chk("match irq", cmpIrq, 1'b1);
            chk("masked irq", ovIrq, 1'b0);
            c = '0;
            c.compareIrqAck = 1'b1;
            c.overflowFlagClr = 1'b1;
            put(c);
            chk("flags cleared", {stat.overflowFlag, stat.compareMatchFlag}, 2'b00);
        end
        cf.waveformModeSelect = TMR_WGM_NORMAL;
        setc();
        for (int k = 0; k < 2; k++)
        begin
            wr(8'h40, 1);
            wr(8'h40 - 8'(k * 2), 0);
            clr();
            runfor(6);
            chk("blocked match", stat.compareMatchFlag, 8'(k));
        end
        clr();
        ex = oc;
        foreach (coms[j])
        begin
            cf.compareOutputMode = coms[j];
            setc();
            chk("override", ocOe, 8'(coms[j] != TMR_COM_NONE));
            ex = wave(coms[j], ex);
            force_cmp();
            chk("forced output", oc, ex);
        end
        chk("force flag", stat.compareMatchFlag, 1'b0);
        cf.waveformModeSelect = TMR_WGM_FAST;
        cf.compareOutputMode = TMR_COM_TOGGLE;
        setc();
        force_cmp();
        chk("pwm force", oc, ex);
        cf.waveformModeSelect = TMR_WGM_CTC;
        setc();
        chk("mode change", oc, ex);
        cf.waveformModeSelect = TMR_WGM_NORMAL;
        cf.compareOutputMode = TMR_COM_CLEAR;
        setc();
        wr(8'h20, 1);
        cf.waveformModeSelect = TMR_WGM_FAST;
        setc();
        wr(8'h80, 1);
        chk("buffer", stat.compareValue, 8'h80);
        cf.waveformModeSelect = TMR_WGM_NORMAL;
        setc();
        chk("direct", stat.compareValue, 8'h20);
        cf.waveformModeSelect = TMR_WGM_FAST;
        setc();
        wr(8'hf0, 0);
        cf.clockSourceSelect = 3'h1;
        setc();
        reach(8'h10);
        chk("pwm bottom", oc, 1'b1);
        reach(8'h90);
        chk("pwm match", oc, 1'b0);
        cf.clockSourceSelect = TMR_CS_STOP;
        cf.waveformModeSelect = TMR_WGM_NORMAL;
        setc();
        chk("reloaded", stat.compareValue, 8'h80);
        wr(8'h00, 0);
        cf.asyncClockSelect = 1'b1;
        cf.clockSourceSelect = 3'h1;
        setc();
        step(10);
        chk("crystal idle", stat.counterValue, 8'h00);
        repeat (3)
        begin
            @(posedge clk);
            pinA <= 1'b1;
            step(10);
            @(posedge clk);
            pinA <= 1'b0;
            step(10);
        end
        chk("crystal ticks", stat.counterValue, 8'h03);
        // Dual-slope run from the io clock: the count must turn at max.
        cf.asyncClockSelect = 1'b0;
        cf.overflowIrqEnable = 1'b1;
        cf.waveformModeSelect = TMR_WGM_PHASE;
        setc();
        chk("overflow irq", ovIrq, 1'b1);
        reach(8'hff);
        step(1);
        chk("phase down", stat.counterValue, 8'hfe);
        report_and_stop();
    end
endmodule
